// ---- sptm_timer.sv ----
// supervision timer behind two write-only host i/o ports
// assumes io_wr is a one-cycle strobe with io_addr and io_data valid
`timescale 1ns/1ps
`default_nettype none
module sptm_timer #(
    parameter int CYCLES_PER_SEC = sptm_pkg::CYCLES_PER_SEC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // host i/o write port
    input wire logic io_wr,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_data,
    // status and system reset
    output logic running,
    output logic [5:0] seconds_left,
    output logic sys_reset
);
    ////////////////////////////////////////////////////////////////////
    // decode and timeout table

    function automatic logic [5:0] timeout_sec(input logic [3:0] code);
        timeout_sec = sptm_pkg::TIMEOUT_BASE_SEC
            - 6'(sptm_pkg::TIMEOUT_STEP_SEC * code);
    endfunction

    logic wr_disable;
    logic wr_reload;
    logic tick;
    assign wr_disable = io_wr && (io_addr == sptm_pkg::DISABLE_PORT);
    assign wr_reload = io_wr && (io_addr == sptm_pkg::RELOAD_PORT);

    ////////////////////////////////////////////////////////////////////
    // second divider, restarted by every reload

    sptm_tick #(
        .PERIOD(CYCLES_PER_SEC)
    ) u_tick (
        .mclk(mclk),
        .nrst(nrst),
        .clear(wr_reload || wr_disable),
        .tick(tick)
    );

    ////////////////////////////////////////////////////////////////////
    // countdown state

    sptm_pkg::sptm_state_type state;
    sptm_pkg::sptm_state_type next_state;
    logic [5:0] remain;
    logic [5:0] next_remain;
    logic [7:0] pulse;
    logic [7:0] next_pulse;
    logic next_running;
    logic next_sys_reset;

    // next values of the countdown
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_pulse = pulse;
        unique case (state)
            sptm_pkg::SPTM_OFF: begin
                next_remain = 6'h00;
            end
            sptm_pkg::SPTM_RUN: begin
                if (remain == 6'h00) begin
                    next_state = sptm_pkg::SPTM_FIRE;
                    next_pulse = sptm_pkg::RESET_PULSE_LEN;
                end else if (tick) begin
                    next_remain = remain - 6'h01;
                end
            end
            sptm_pkg::SPTM_FIRE: begin
                if (pulse <= 8'h01) begin
                    next_state = sptm_pkg::SPTM_OFF; // reset done, rearm on reload
                    next_pulse = 8'h00;
                end else begin
                    next_pulse = pulse - 8'h01;
                end
            end
        endcase
        // host writes take priority over the countdown
        if (wr_reload) begin
            next_state = sptm_pkg::SPTM_RUN;
            next_remain = timeout_sec(io_data[sptm_pkg::SETTING_BITS-1:0]);
            next_pulse = 8'h00;
        end else if (wr_disable) begin
            next_state = sptm_pkg::SPTM_OFF;
            next_remain = 6'h00;
            next_pulse = 8'h00;
        end
        next_running = (next_state == sptm_pkg::SPTM_RUN);
        next_sys_reset = (next_state == sptm_pkg::SPTM_FIRE);
    end

    // register the countdown; start off after reset
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= sptm_pkg::SPTM_OFF;
            remain <= 6'h00;
            pulse <= 8'h00;
            running <= 1'b0;
            seconds_left <= 6'h00;
            sys_reset <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            pulse <= next_pulse;
            running <= next_running;
            seconds_left <= next_remain;
            sys_reset <= next_sys_reset;
        end
    end
endmodule // sptm_timer
`default_nettype wire

// ---- sptm_pkg.sv ----
// package for the io-port supervision timer
// assumes a 200 MHz mclk and host i/o writes presented as one-cycle strobes
`default_nettype none
package sptm_pkg;
    // i/o port addresses
    localparam logic [15:0] DISABLE_PORT = 16'h0441;
    localparam logic [15:0] RELOAD_PORT = 16'h0443;
    // timeout arithmetic: seconds = base - step * code
    localparam logic [5:0] TIMEOUT_BASE_SEC = 6'h1E;
    localparam logic [5:0] TIMEOUT_STEP_SEC = 6'h02;
    localparam int SETTING_BITS = 4;
    // clock and second tick
    localparam int CLOCK_HZ = 200_000_000;
    localparam int CYCLES_PER_SEC = CLOCK_HZ;
    // reset pulse length on expiry
    localparam int RESET_PULSE_NS = 1000;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] RESET_PULSE_LEN = 8'(RESET_PULSE_CYCLES);
    // states of the timer
    typedef enum logic [1:0] {SPTM_OFF, SPTM_RUN, SPTM_FIRE} sptm_state_type;
endpackage
`default_nettype wire

// ---- sptm_tick.sv ----
// one-second enable pulse divider
// assumes a single clock; clear restarts the second boundary
`timescale 1ns/1ps
`default_nettype none
module sptm_tick #(
    parameter int PERIOD = 200_000_000
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // control
    input wire logic clear,
    output logic tick
);
    logic [31:0] count;
    logic [31:0] next_count;
    logic next_tick;

    // count cycles, pulse at the end of each period
    always_comb begin
        next_tick = 1'b0;
        next_count = count + 32'h00000001;
        if (clear) begin
            next_count = 32'h00000000;
        end else if (count == 32'(PERIOD - 1)) begin
            next_count = 32'h00000000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            count <= 32'h00000000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // sptm_tick
`default_nettype wire

// ---- sptm_timer_monitor.sv ----
// port checker for the supervision timer
// bound to sptm_timer from the bench
`timescale 1ns/1ps
`default_nettype none
module sptm_timer_monitor (
    // watched ports
    input wire logic mclk, nrst, io_wr, running, sys_reset,
    input wire logic [15:0] io_addr, io_data,
    input wire logic [5:0] seconds_left
);
    // decoded writes and coded period
    wire dis = io_wr && io_addr == 16'h0441;
    wire rl = io_wr && io_addr == 16'h0443;
    wire [5:0] want = 6'h1E - {1'b0, io_data[3:0], 1'b0};
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    stop_on_dis_a:
        assert property (dis |=> !running && !sys_reset) else $error("no stop");
    reload_arm_a:
        assert property (rl |=> running && !sys_reset) else $error("no arm");
    reload_len_a:
        assert property (rl |=> seconds_left == $past(want)) else $error("bad period");
    stay_off_a:
        assert property (!running && !rl |=> !running) else $error("ran unarmed");
    boot_idle_a:
        assert property ($rose(nrst) |-> !running && !sys_reset) else $error("busy at boot");
    expire_rst_a:
        assert property (running && seconds_left == 6'h00 && !io_wr |-> ##[1:2] sys_reset)
        else $error("no reset");
    pulse_hold_a:
        assert property ($rose(sys_reset) ##1 (!rl)[*7] |-> sys_reset) else $error("short");
    // main scenarios
    cover property (dis && running);
    cover property ($rose(sys_reset));
    cover property (rl && sys_reset);
endmodule // sptm_timer_monitor
`default_nettype wire

// ---- sptm_host.sv ----
// host software model writing the i/o ports
// assumes the bench calls put from its main sequence
`timescale 1ns/1ps
`default_nettype none
module sptm_host (
    // clock
    input wire logic mclk,
    // host i/o write port
    output logic io_wr,
    output logic [15:0] io_addr,
    output logic [15:0] io_data
);
    initial begin
        io_wr = 1'b0;
        io_addr = 16'h0000;
        io_data = 16'h0000;
    end
    // one-cycle strobe; released bus shows the inverse
    task put(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        io_wr <= 1'b1;
        io_addr <= a;
        io_data <= d;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_addr <= ~a;
        io_data <= ~d;
    endtask
endmodule // sptm_host
`default_nettype wire

// ---- sptm_timer_tb_top.sv ----
// bench: host model drives the timer, rows walk every code
// assumes one second shortened to four mclk cycles
`timescale 1ns/1ps
`default_nettype none
module sptm_timer_tb_top;
    logic mclk, nrst, io_wr, running, sys_reset;
    logic [15:0] io_addr, io_data;
    logic [5:0] seconds_left;
    logic [9:0] rows [16];
    int n_fail, checks_done, n;
    wire [7:0] st = {running, sys_reset, seconds_left};
    sptm_host host (.mclk(mclk), .io_wr(io_wr), .io_addr(io_addr), .io_data(io_data));
    sptm_timer #(.CYCLES_PER_SEC(4)) DUT (.mclk(mclk), .nrst(nrst), .io_wr(io_wr),
        .io_addr(io_addr), .io_data(io_data), .running(running),
        .seconds_left(seconds_left), .sys_reset(sys_reset));
    task chk(input string s, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s exp %h got %h", s, exp, got);
        end
    endtask
    task summarize;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // bounded wait for the system reset
    task fire;
        n = 0;
        while (sys_reset !== 1'b1 && n < 40) begin
            @(posedge mclk);
            #1 n++;
        end
        if (sys_reset !== 1'b1) begin
            n_fail++;
            summarize();
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // rows of code and period, then hand-made cases
    initial begin
        nrst = 1'b0;
        n_fail = 0;
        checks_done = 0;
        for (int k = 0; k < 16; k++) rows[k] = {4'(k), 6'(30 - 2 * k)};
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        host.put(16'h0442, 16'h0443);
        #1 chk("idle", st, 8'h00);
        foreach (rows[k]) begin
            host.put(16'h0443, {12'hA5A, rows[k][9:6]});
            #1 chk("load", st, {2'b10, rows[k][5:0]});
        end
        fire();
        chk("zero", 8'(n), 8'h01);
        repeat (9) @(posedge mclk);
        host.put(16'h0443, 16'h0000);
        #1 chk("rearm", st, 8'h9E);
        host.put(16'h0441, 16'hFFFF);
        #1 chk("stop", st, 8'h00);
        repeat (140) @(posedge mclk);
        #1 chk("quiet", st, 8'h00);
        // mid-run reset while counting: timer must come back off
        host.put(16'h0443, 16'h0000);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        #1 chk("reboot", st, 8'h00);
        repeat (40) @(posedge mclk);
        #1 chk("reboot_quiet", st, 8'h00);
        host.put(16'h0443, 16'h000D);
        fire();
        chk("span", 8'(n > 14 && n < 20), 8'h01);
        chk("fired", st, 8'h40);
        summarize();
    end
endmodule // sptm_timer_tb_top
bind sptm_timer sptm_timer_monitor mon (.mclk(mclk), .nrst(nrst), .io_wr(io_wr),
    .io_addr(io_addr), .io_data(io_data), .running(running), .sys_reset(sys_reset),
    .seconds_left(seconds_left));
`default_nettype wire
